// >>> core/bal_byte_alu.sv
/*
 * Byte ALU top: 8-bit arithmetic and logic, word add and subtract on a
 * register pair over two cycles, plus the I/O access path.
 * Assumes the decoder holds off new requests while busy is high.
 */
`timescale 1ns/1ps
module bal_byte_alu
    import bal_pkg::*;
(
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire bal_alu_req_t aluReq,
    input  wire logic         carryIn,
    input  wire bal_io_req_t  ioReq,
    output bal_alu_rsp_t      aluRsp,
    output logic              busy,
    output bal_io_rsp_t       ioRsp
);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_WORD = 2'b10
    } bal_state_t;

    typedef struct packed {
        bal_state_t   fsm;
        bal_alu_rsp_t rsp;
        logic         busy;
        logic [15:0]  wordRes;
        logic [7:0]   wordFlags;
    } bal_alu_state_t;

    bal_alu_state_t state_reg;
    bal_alu_state_t state_next;

    // -----------------------------------------------------------------
    // Byte flag helpers
    // -----------------------------------------------------------------
    function automatic logic [7:0] logicFlags(input logic [7:0] r, input logic [7:0] old);
        logic [7:0] f;
        f         = old;
        f[FLAG_Z] = (r == 8'h00);
        f[FLAG_N] = r[7];
        f[FLAG_V] = 1'b0;
        f[FLAG_S] = r[7];
        return f;
    endfunction : logicFlags

    function automatic logic [7:0] addFlags(input logic [7:0] a, input logic [7:0] b,
                                            input logic [8:0] s, input logic [7:0] old);
        logic [7:0] f;
        f         = old;
        f[FLAG_C] = s[8];
        f[FLAG_Z] = (s[7:0] == 8'h00);
        f[FLAG_N] = s[7];
        f[FLAG_V] = (a[7] == b[7]) && (s[7] != a[7]);
        f[FLAG_S] = f[FLAG_N] ^ f[FLAG_V];
        f[FLAG_H] = (a[3] & b[3]) | (b[3] & ~s[3]) | (~s[3] & a[3]);
        return f;
    endfunction : addFlags

    function automatic logic [7:0] subFlags(input logic [7:0] a, input logic [7:0] b,
                                            input logic [8:0] d, input logic [7:0] old,
                                            input logic chainZ);
        logic [7:0] f;
        f         = old;
        f[FLAG_C] = d[8];
        // Borrow forms keep Z only if it was already set, for multi-byte compares
        f[FLAG_Z] = (d[7:0] == 8'h00) && (!chainZ || old[FLAG_Z]);
        f[FLAG_N] = d[7];
        f[FLAG_V] = (a[7] != b[7]) && (d[7] != a[7]);
        f[FLAG_S] = f[FLAG_N] ^ f[FLAG_V];
        f[FLAG_H] = (~a[3] & b[3]) | (b[3] & d[3]) | (d[3] & ~a[3]);
        return f;
    endfunction : subFlags

    // -----------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------
    always_comb begin
        logic [7:0]  opB;
        logic [7:0]  fl;
        logic [8:0]  wide;
        logic [16:0] word;
        logic [15:0] pair;
        opB        = aluReq.srcIsImm ? aluReq.imm : aluReq.src;
        fl         = state_reg.rsp.flags;
        wide       = 9'h000;
        word       = 17'h00000;
        pair       = {aluReq.dstHigh, aluReq.dst};
        state_next = state_reg;
        state_next.rsp.valid     = 1'b0;
        state_next.rsp.wordWrite = 1'b0;
        state_next.rsp.writeBack = 1'b0;
        case (state_reg.fsm)
            ST_IDLE: begin
                if (aluReq.valid) begin
                    state_next.rsp.valid     = 1'b1;
                    state_next.rsp.writeBack = 1'b1;
                    state_next.rsp.result    = {8'h00, aluReq.dst};
                    case (aluReq.op)
                        BAL_ADD, BAL_ADD_C: begin
                            wide = {1'b0, aluReq.dst} + {1'b0, aluReq.src}
                                 + {8'h00, (aluReq.op == BAL_ADD_C) & carryIn};
                            state_next.rsp.result = {8'h00, wide[7:0]};
                            state_next.rsp.flags  = addFlags(aluReq.dst, aluReq.src, wide, fl);
                        end
                        BAL_SUB, BAL_COMPARE: begin
                            wide = {1'b0, aluReq.dst} - {1'b0, opB};
                            state_next.rsp.result    = {8'h00, wide[7:0]};
                            state_next.rsp.writeBack = (aluReq.op == BAL_SUB);
                            state_next.rsp.flags     = subFlags(aluReq.dst, opB, wide, fl, 1'b0);
                        end
                        BAL_SUB_C, BAL_COMP_C: begin
                            wide = {1'b0, aluReq.dst} - {1'b0, opB}
                                 - {8'h00, carryIn};
                            state_next.rsp.result    = {8'h00, wide[7:0]};
                            state_next.rsp.writeBack = (aluReq.op == BAL_SUB_C);
                            state_next.rsp.flags     = subFlags(aluReq.dst, opB, wide, fl, 1'b1);
                        end
                        BAL_WORD_ADD, BAL_WORD_SUB: begin
                            // Result and flags appear on the second cycle only
                            state_next.rsp.valid     = 1'b0;
                            state_next.rsp.writeBack = 1'b0;
                            state_next.fsm           = ST_WORD;
                            state_next.busy          = 1'b1;
                            if (aluReq.op == BAL_WORD_ADD) begin
                                word = {1'b0, pair} + {9'h000, aluReq.imm};
                                // Carry is the bit out of the top of the pair
                                state_next.wordFlags[FLAG_C] = word[16];
                                state_next.wordFlags[FLAG_V] = ~pair[15] & word[15];
                            end else begin
                                word = {1'b0, pair} - {9'h000, aluReq.imm};
                                state_next.wordFlags[FLAG_C] = word[15] & ~pair[15];
                                state_next.wordFlags[FLAG_V] = pair[15] & ~word[15];
                            end
                            state_next.wordRes           = word[15:0];
                            state_next.wordFlags[FLAG_Z] = (word[15:0] == WORD_RESET);
                            state_next.wordFlags[FLAG_N] = word[15];
                            state_next.wordFlags[FLAG_S] = word[15] ^ state_next.wordFlags[FLAG_V];
                            state_next.wordFlags[FLAG_H] = fl[FLAG_H];
                        end
                        BAL_AND: begin
                            state_next.rsp.result = {8'h00, aluReq.dst & opB};
                            state_next.rsp.flags  = logicFlags(aluReq.dst & opB, fl);
                        end
                        BAL_OR, BAL_SET_BITS: begin
                            state_next.rsp.result = {8'h00, aluReq.dst | opB};
                            state_next.rsp.flags  = logicFlags(aluReq.dst | opB, fl);
                        end
                        BAL_XOR: begin
                            state_next.rsp.result = {8'h00, aluReq.dst ^ aluReq.src};
                            state_next.rsp.flags  = logicFlags(aluReq.dst ^ aluReq.src, fl);
                        end
                        BAL_CLR_BITS: begin
                            state_next.rsp.result =
                                {8'h00, aluReq.dst & (BYTE_ALL_ONES - aluReq.imm)};
                            state_next.rsp.flags  =
                                logicFlags(aluReq.dst & (BYTE_ALL_ONES - aluReq.imm), fl);
                        end
                        BAL_TEST: begin
                            state_next.rsp.result = {8'h00, aluReq.dst & aluReq.dst};
                            state_next.rsp.flags  = logicFlags(aluReq.dst, fl);
                        end
                        BAL_INVERT: begin
                            state_next.rsp.result = {8'h00, BYTE_ALL_ONES - aluReq.dst};
                            state_next.rsp.flags  = logicFlags(~aluReq.dst, fl);
                            state_next.rsp.flags[FLAG_C] = 1'b1;
                        end
                        BAL_NEGATE: begin
                            wide = 9'h000 - {1'b0, aluReq.dst};
                            state_next.rsp.result = {8'h00, wide[7:0]};
                            state_next.rsp.flags  = subFlags(8'h00, aluReq.dst, wide, fl, 1'b0);
                            state_next.rsp.flags[FLAG_C] = (wide[7:0] != 8'h00);
                        end
                        BAL_INC, BAL_DEC: begin
                            wide = (aluReq.op == BAL_INC) ? {1'b0, aluReq.dst} + 9'h001
                                                          : {1'b0, aluReq.dst} - 9'h001;
                            state_next.rsp.result = {8'h00, wide[7:0]};
                            state_next.rsp.flags  = logicFlags(wide[7:0], fl);
                            state_next.rsp.flags[FLAG_V] = (aluReq.op == BAL_INC)
                                ? (aluReq.dst == 8'h7f) : (aluReq.dst == 8'h80);
                            state_next.rsp.flags[FLAG_S] = wide[7] ^ state_next.rsp.flags[FLAG_V];
                        end
                        BAL_ZERO: begin
                            state_next.rsp.result = {8'h00, aluReq.dst ^ aluReq.dst};
                            state_next.rsp.flags  = logicFlags(8'h00, fl);
                        end
                        default: begin
                            state_next.rsp.valid     = 1'b0;
                            state_next.rsp.writeBack = 1'b0;
                        end
                    endcase
                end
            end
            ST_WORD: begin
                state_next.fsm           = ST_IDLE;
                state_next.busy          = 1'b0;
                state_next.rsp.valid     = 1'b1;
                state_next.rsp.writeBack = 1'b1;
                state_next.rsp.wordWrite = 1'b1;
                state_next.rsp.result    = state_reg.wordRes;
                state_next.rsp.flags     = state_reg.wordFlags;
            end
            default: begin
                state_next.fsm  = ST_IDLE;
                state_next.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg           <= '0;
            state_reg.fsm       <= ST_IDLE;
            state_reg.rsp.flags <= FLAGS_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // -----------------------------------------------------------------
    // I/O access path
    // -----------------------------------------------------------------
    bal_io_access uIo (
        .clock (clock),
        .rst   (rst),
        .ioReq (ioReq),
        .ioRsp (ioRsp)
    );

    assign aluRsp = state_reg.rsp;
    assign busy   = state_reg.busy;

endmodule : bal_byte_alu

// >>> common/bal_pkg.sv
/*
 * Package for the byte ALU and I/O bit access unit: operation codes,
 * flag positions, I/O address limits and the carrier structs.
 * Assumes one core clock and a decoder that presents one operation a cycle.
 */
package bal_pkg;

    typedef enum logic [4:0] {
        BAL_ADD      = 5'h00,
        BAL_ADD_C    = 5'h01,
        BAL_WORD_ADD = 5'h02,
        BAL_SUB      = 5'h03,
        BAL_SUB_C    = 5'h04,
        BAL_WORD_SUB = 5'h05,
        BAL_AND      = 5'h06,
        BAL_OR       = 5'h07,
        BAL_XOR      = 5'h08,
        BAL_SET_BITS = 5'h09,
        BAL_CLR_BITS = 5'h0a,
        BAL_TEST     = 5'h0b,
        BAL_INVERT   = 5'h0c,
        BAL_NEGATE   = 5'h0d,
        BAL_INC      = 5'h0e,
        BAL_DEC      = 5'h0f,
        BAL_ZERO     = 5'h10,
        BAL_COMPARE  = 5'h11,
        BAL_COMP_C   = 5'h12
    } bal_op_t;

    typedef enum logic [3:0] {
        BAL_IO_READ     = 4'h0,
        BAL_IO_WRITE    = 4'h1,
        BAL_IO_BIT_SET  = 4'h2,
        BAL_IO_BIT_CLR  = 4'h3,
        BAL_IO_SKIP_HI  = 4'h4,
        BAL_IO_SKIP_LO  = 4'h5,
        BAL_MEM_LOAD    = 4'h6,
        BAL_MEM_WRITE   = 4'h7
    } bal_io_op_t;

    // Flag positions in the status byte
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;

    localparam logic [7:0]  BYTE_ALL_ONES   = 8'hff;
    localparam logic [7:0]  IO_BIT_LAST     = 8'h1f;
    localparam logic [7:0]  IO_PORT_LAST    = 8'h3f;
    localparam logic [7:0]  IO_DATA_OFFSET  = 8'h20;
    localparam logic [7:0]  EXT_IO_FIRST    = 8'h60;
    localparam logic [7:0]  EXT_IO_LAST     = 8'hff;
    localparam logic [7:0]  DATA_IO_LAST    = 8'h5f;
    localparam logic [7:0]  FLAGS_RESET     = 8'h00;
    localparam logic [15:0] WORD_RESET      = 16'h0000;
    localparam logic [1:0]  WORD_OP_CYCLES  = 2'h2;

    typedef struct packed {
        logic        valid;
        bal_op_t     op;
        logic [7:0]  dst;
        logic [7:0]  src;
        logic        srcIsImm;
        logic [7:0]  imm;
        logic [7:0]  dstHigh;
    } bal_alu_req_t;

    typedef struct packed {
        logic        valid;
        logic        wordWrite;
        logic        writeBack;
        logic [15:0] result;
        logic [7:0]  flags;
    } bal_alu_rsp_t;

    typedef struct packed {
        logic        valid;
        bal_io_op_t  op;
        logic [7:0]  addr;
        logic [2:0]  bitSel;
        logic [7:0]  wrData;
        logic [7:0]  curData;
        logic [7:0]  w1cMask;
    } bal_io_req_t;

    typedef struct packed {
        logic        valid;
        logic        illegal;
        logic        write;
        logic [7:0]  dataAddr;
        logic [7:0]  wrData;
        logic        skip;
    } bal_io_rsp_t;

endpackage : bal_pkg

// >>> core/bal_io_access.sv
/*
 * I/O access path: range checks, data-space mapping, single-bit
 * set and clear, bit-test skips and write-one-to-clear merging.
 * Assumes the register file supplies the current I/O value with the request.
 */
`timescale 1ns/1ps
module bal_io_access
    import bal_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire bal_io_req_t ioReq,
    output bal_io_rsp_t      ioRsp
);

    typedef struct packed {
        bal_io_rsp_t rsp;
    } bal_io_state_t;

    bal_io_state_t state_reg;
    bal_io_state_t state_next;

    always_comb begin
        logic [7:0] bitMask;
        logic       inBitRange;
        logic       inPortRange;
        logic [7:0] keepFlags;
        bitMask     = 8'h01 << ioReq.bitSel;
        inBitRange  = (ioReq.addr <= IO_BIT_LAST);
        inPortRange = (ioReq.addr <= IO_PORT_LAST);
        // Write-one-to-clear bits are merged as zero so a bit set or clear keeps them
        keepFlags   = ioReq.curData & ~ioReq.w1cMask;
        state_next  = '0;
        state_next.rsp.valid    = ioReq.valid;
        state_next.rsp.dataAddr = ioReq.addr + IO_DATA_OFFSET;
        if (ioReq.valid) begin
            case (ioReq.op)
                BAL_IO_READ: begin
                    state_next.rsp.illegal = !inPortRange;
                end
                BAL_IO_WRITE: begin
                    state_next.rsp.illegal = !inPortRange;
                    state_next.rsp.write   = inPortRange;
                    state_next.rsp.wrData  = ioReq.wrData;
                end
                BAL_IO_BIT_SET: begin
                    state_next.rsp.illegal = !inBitRange;
                    state_next.rsp.write   = inBitRange;
                    state_next.rsp.wrData  = keepFlags | bitMask;
                end
                BAL_IO_BIT_CLR: begin
                    state_next.rsp.illegal = !inBitRange;
                    state_next.rsp.write   = inBitRange;
                    // A flag at the cleared bit is written zero, so it is left pending
                    state_next.rsp.wrData  = keepFlags & ~bitMask;
                end
                BAL_IO_SKIP_HI: begin
                    state_next.rsp.illegal = !inBitRange;
                    state_next.rsp.skip    = inBitRange && |(ioReq.curData & bitMask);
                end
                BAL_IO_SKIP_LO: begin
                    state_next.rsp.illegal = !inBitRange;
                    state_next.rsp.skip    = inBitRange && !(|(ioReq.curData & bitMask));
                end
                BAL_MEM_LOAD: begin
                    state_next.rsp.dataAddr = ioReq.addr;
                end
                BAL_MEM_WRITE: begin
                    state_next.rsp.dataAddr = ioReq.addr;
                    state_next.rsp.write    = 1'b1;
                    state_next.rsp.wrData   = ioReq.wrData;
                end
                default: begin
                    state_next.rsp.illegal = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign ioRsp = state_reg.rsp;

endmodule : bal_io_access

// >>> dv/bal_regfile_model.sv
/*
 * Far-side model: one I/O register of the core's register file.
 * Assumes the bench feeds ioValue back as curData of the next request.
 */
`timescale 1ns/1ps
module bal_regfile_model
    import bal_pkg::*;
#(
    parameter logic [7:0] USED_BITS = 8'hff,
    parameter logic [7:0] START     = 8'h81
)(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire bal_io_rsp_t ioRsp,
    output logic [7:0]       ioValue
);
    always_ff @(posedge clock) begin
        if (rst) begin
            ioValue <= START;
        end else if (ioRsp.valid && ioRsp.write) begin
            // Unused bits stored as zero to stay forward compatible
            ioValue <= ioRsp.wrData & USED_BITS;
        end
    end
endmodule : bal_regfile_model

// >>> dv/bal_byte_alu_asserts.sv
/*
 * Checker for the byte ALU top, bound to its ports.
 * Assumes one clock domain and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module bal_byte_alu_asserts
    import bal_pkg::*;
(
    input wire logic         clock,
    input wire logic         rst,
    input wire bal_alu_req_t aluReq,
    input wire logic         carryIn,
    input wire bal_io_req_t  ioReq,
    input wire bal_alu_rsp_t aluRsp,
    input wire logic         busy,
    input wire bal_io_rsp_t  ioRsp
);
    logic take;
    logic takeWord;
    logic ioBit;
    assign take     = aluReq.valid && !busy;
    assign takeWord = take && aluReq.op inside {BAL_WORD_ADD, BAL_WORD_SUB};
    assign ioBit    = ioReq.valid && ioReq.op inside {BAL_IO_BIT_SET, BAL_IO_BIT_CLR,
                                                      BAL_IO_SKIP_HI, BAL_IO_SKIP_LO};
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    AST_BYTE_ONE_CYCLE: assert property (take && !takeWord |=>
        aluRsp.valid && !aluRsp.wordWrite) else $error("byte op answer late or marked as word");
    AST_WORD_TWO_CYCLES: assert property (takeWord |=> busy && !aluRsp.valid ##1
        aluRsp.valid && aluRsp.wordWrite && !busy) else $error("word op timing wrong");
    AST_ADD_SUM: assert property (take && aluReq.op == BAL_ADD |=>
        aluRsp.result[7:0] == 8'($past(aluReq.dst) + $past(aluReq.src))) else $error("bad sum");
    AST_AND_FLAGS: assert property (take && aluReq.op == BAL_AND |=>
        !aluRsp.flags[FLAG_V] && $stable(aluRsp.flags[FLAG_C]) &&
        aluRsp.flags[FLAG_Z] == (aluRsp.result[7:0] == 8'h00)) else $error("and flags wrong");
    AST_CLR_BITS: assert property (take && aluReq.op == BAL_CLR_BITS |=>
        aluRsp.result[7:0] == ($past(aluReq.dst) & (BYTE_ALL_ONES - $past(aluReq.imm))))
        else $error("bit clear result wrong");
    AST_IO_ANSWER: assert property (ioReq.valid |=> ioRsp.valid)
        else $error("io request not answered");
    AST_BIT_RANGE: assert property (ioBit && ioReq.addr > IO_BIT_LAST |=>
        ioRsp.illegal && !ioRsp.write) else $error("bit op beyond range accepted");
    AST_PORT_RANGE: assert property (ioReq.valid &&
        ioReq.op inside {BAL_IO_READ, BAL_IO_WRITE} && ioReq.addr > IO_PORT_LAST |=>
        ioRsp.illegal && !ioRsp.write) else $error("io port op beyond range accepted");
    AST_IO_MAP: assert property (ioReq.valid && ioReq.op == BAL_IO_WRITE &&
        ioReq.addr <= IO_PORT_LAST |=> ioRsp.write &&
        ioRsp.dataAddr == $past(ioReq.addr) + IO_DATA_OFFSET) else $error("io data address wrong");
    AST_BIT_ONLY: assert property (ioReq.valid && ioReq.op == BAL_IO_BIT_SET &&
        ioReq.addr <= IO_BIT_LAST && !ioReq.w1cMask[ioReq.bitSel] |=> ioRsp.wrData ==
        (($past(ioReq.curData) & ~$past(ioReq.w1cMask)) | (8'h01 << $past(ioReq.bitSel))))
        else $error("bit set touched other bits");
endmodule : bal_byte_alu_asserts

bind bal_byte_alu bal_byte_alu_asserts u_chk (.clock(clock), .rst(rst), .aluReq(aluReq),
    .carryIn(carryIn), .ioReq(ioReq), .aluRsp(aluRsp), .busy(busy), .ioRsp(ioRsp));

// >>> dv/bal_byte_alu_test.sv
/*
 * Self-checking bench for the byte ALU top with a register-file model.
 * Assumes package, design and checker files are compiled before it.
 */
`timescale 1ns/1ps
module bal_byte_alu_test;
    import bal_pkg::*;
    logic         clock;
    logic         rst;
    bal_alu_req_t aluReq;
    logic         carryIn;
    bal_io_req_t  ioReq;
    bal_alu_rsp_t aluRsp;
    logic         busy;
    bal_io_rsp_t  ioRsp;
    logic [7:0]   ioValue;
    int           n_mismatch;
    int           checked;
    int           cycles;

    bal_byte_alu i_dut (.clock(clock), .rst(rst), .aluReq(aluReq), .carryIn(carryIn),
        .ioReq(ioReq), .aluRsp(aluRsp), .busy(busy), .ioRsp(ioRsp));
    bal_regfile_model i_regs (.clock(clock), .rst(rst), .ioRsp(ioRsp), .ioValue(ioValue));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // ----------------
    // Shared tasks
    // ----------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wrap_up();
        if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    // Back to back: valid stays high, next call overwrites the request
    task automatic op(input bal_op_t code, input logic [7:0] a, input logic [7:0] b,
                      input logic isImm, input logic cin, input logic [7:0] res,
                      input logic [7:0] m, input logic [7:0] f);
        aluReq = '{1'b1, code, a, b, isImm, b, 8'h00};
        carryIn = cin;
        @(posedge clock) #1;
        check("result", aluRsp.result, {8'h00, res});
        check("flags", {8'h00, aluRsp.flags & m}, {8'h00, f});
        check("write back", {14'h0, aluRsp.valid, aluRsp.writeBack},
              {14'h0, 1'b1, !(code inside {BAL_COMPARE, BAL_COMP_C})});
    endtask : op

    // Idle cycle after each access so the model's write lands first
    task automatic io(input bal_io_op_t code, input logic [7:0] addr, input logic [2:0] sel,
                      input logic [7:0] wr, input logic [7:0] w1c, input logic ill,
                      input logic wrt, input logic [7:0] da, input logic [7:0] wd,
                      input logic skp);
        ioReq = '{1'b1, code, addr, sel, wr, ioValue, w1c};
        @(posedge clock) #1;
        check("io flags", {12'h0, ioRsp.valid, ioRsp.illegal, ioRsp.write, ioRsp.skip},
              {12'h0, 1'b1, ill, wrt, skp});
        if (wrt) check("io write", {ioRsp.dataAddr, ioRsp.wrData}, {da, wd});
        ioReq.valid = 1'b0;
        @(posedge clock) #1;
    endtask : io

    // ----------------
    // Scenarios
    // ----------------
    task automatic t_arith();
        // Compares store nothing; the borrow form keeps Z only if already set
        op(BAL_COMPARE, 8'h05, 8'h05, 1'b0, 1'b0, 8'h00, 8'h2f, 8'h02);
        op(BAL_COMP_C, 8'h05, 8'h05, 1'b0, 1'b0, 8'h00, 8'h2f, 8'h02);
        op(BAL_ADD, 8'h0f, 8'h01, 1'b0, 1'b0, 8'h10, 8'h2f, 8'h20);
        op(BAL_ADD_C, 8'hff, 8'h00, 1'b0, 1'b1, 8'h00, 8'h2f, 8'h23);
        op(BAL_ADD, 8'h7f, 8'h01, 1'b0, 1'b0, 8'h80, 8'h2f, 8'h2c);
        op(BAL_SUB, 8'h10, 8'h01, 1'b1, 1'b0, 8'h0f, 8'h2f, 8'h20);
        op(BAL_SUB, 8'h80, 8'h01, 1'b0, 1'b0, 8'h7f, 8'h2f, 8'h28);
        op(BAL_SUB_C, 8'h00, 8'h00, 1'b0, 1'b1, 8'hff, 8'h2f, 8'h25);
        op(BAL_SUB_C, 8'h05, 8'h05, 1'b1, 1'b0, 8'h00, 8'h2f, 8'h00);
    endtask : t_arith

    task automatic t_logic();
        op(BAL_SUB, 8'h00, 8'h01, 1'b0, 1'b0, 8'hff, 8'h01, 8'h01);
        op(BAL_AND, 8'hf0, 8'h3c, 1'b0, 1'b0, 8'h30, 8'h0f, 8'h01);
        op(BAL_AND, 8'h0f, 8'hf0, 1'b1, 1'b0, 8'h00, 8'h0f, 8'h03);
        op(BAL_OR, 8'h80, 8'h01, 1'b1, 1'b0, 8'h81, 8'h0f, 8'h05);
        op(BAL_OR, 8'h00, 8'h00, 1'b0, 1'b0, 8'h00, 8'h0f, 8'h03);
        op(BAL_XOR, 8'ha5, 8'ha5, 1'b0, 1'b0, 8'h00, 8'h0f, 8'h03);
        op(BAL_SET_BITS, 8'h10, 8'h81, 1'b1, 1'b0, 8'h91, 8'h0f, 8'h05);
        op(BAL_CLR_BITS, 8'hff, 8'h0f, 1'b1, 1'b0, 8'hf0, 8'h0f, 8'h05);
        op(BAL_TEST, 8'h80, 8'h00, 1'b0, 1'b0, 8'h80, 8'h0f, 8'h05);
        op(BAL_INVERT, 8'h55, 8'h00, 1'b0, 1'b0, 8'haa, 8'h06, 8'h04);
        op(BAL_NEGATE, 8'h01, 8'h00, 1'b0, 1'b0, 8'hff, 8'h06, 8'h04);
        op(BAL_INC, 8'h7f, 8'h00, 1'b0, 1'b0, 8'h80, 8'h06, 8'h04);
        op(BAL_DEC, 8'h01, 8'h00, 1'b0, 1'b0, 8'h00, 8'h06, 8'h02);
        op(BAL_ZERO, 8'h5a, 8'h00, 1'b0, 1'b0, 8'h00, 8'h06, 8'h02);
    endtask : t_logic

    // Word op directly after a byte op, with a request refused while busy
    task automatic t_word();
        aluReq = '{1'b1, BAL_WORD_ADD, 8'hff, 8'h01, 1'b1, 8'h01, 8'h12};
        @(posedge clock) #1;
        check("busy", {15'h0, busy}, 16'h1);
        aluReq.op = BAL_ADD;
        @(posedge clock) #1;
        aluReq.valid = 1'b0;
        check("word add", aluRsp.result, 16'h1300);
        check("word flags", {8'h00, aluRsp.flags & 8'h1f}, 16'h0000);
        check("word strobe", {13'h0, aluRsp.valid, aluRsp.wordWrite, busy}, 16'h0006);
        @(posedge clock) #1;
        // The add offered while busy must leave no answer and no new result
        check("refused", {aluRsp.valid, aluRsp.result[14:0]}, 16'h1300);
        aluReq = '{1'b1, BAL_WORD_SUB, 8'h00, 8'h01, 1'b1, 8'h01, 8'h00};
        @(posedge clock) #1;
        aluReq.valid = 1'b0;
        @(posedge clock) #1;
        check("word sub", aluRsp.result, 16'hffff);
        check("word flags", {8'h00, aluRsp.flags & 8'h1f}, 16'h0015);
    endtask : t_word

    task automatic t_io();
        io(BAL_IO_BIT_SET, 8'h05, 3'h2, 8'h00, 8'h01, 0, 1, 8'h25, 8'h84, 0);
        io(BAL_IO_BIT_CLR, 8'h1f, 3'h7, 8'h00, 8'h00, 0, 1, 8'h3f, 8'h04, 0);
        io(BAL_IO_SKIP_HI, 8'h1f, 3'h2, 8'h00, 8'h00, 0, 0, 8'h00, 8'h00, 1);
        io(BAL_IO_SKIP_LO, 8'h00, 3'h2, 8'h00, 8'h00, 0, 0, 8'h00, 8'h00, 0);
        io(BAL_IO_BIT_SET, 8'h20, 3'h0, 8'h00, 8'h00, 1, 0, 8'h00, 8'h00, 0);
        io(BAL_IO_SKIP_LO, 8'h20, 3'h0, 8'h00, 8'h00, 1, 0, 8'h00, 8'h00, 0);
        io(BAL_IO_WRITE, 8'h3f, 3'h0, 8'h5a, 8'h00, 0, 1, 8'h5f, 8'h5a, 0);
        io(BAL_IO_READ, 8'h40, 3'h0, 8'h00, 8'h00, 1, 0, 8'h00, 8'h00, 0);
        io(BAL_IO_WRITE, 8'h60, 3'h0, 8'h11, 8'h00, 1, 0, 8'h00, 8'h00, 0);
        io(BAL_MEM_WRITE, 8'h60, 3'h0, 8'h3c, 8'h00, 0, 1, 8'h60, 8'h3c, 0);
        io(BAL_MEM_LOAD, 8'hff, 3'h0, 8'h00, 8'h00, 0, 0, 8'h00, 8'h00, 0);
    endtask : t_io

    // Reset in mid-run, with flags left non-zero by the word subtract
    task automatic t_reset();
        rst = 1'b1;
        @(posedge clock) #1;
        rst = 1'b0;
        check("mid reset", {5'h0, ioRsp.valid, aluRsp.valid, busy, aluRsp.flags}, 16'h0000);
    endtask : t_reset

    // Ceiling well above the 72 or so cycles the run needs
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    initial begin
        n_mismatch = 0;
        checked = 0;
        cycles = 0;
        rst = 1'b1;
        carryIn = 1'b0;
        aluReq = '0;
        ioReq = '0;
        repeat (20) @(posedge clock);
        #1 rst = 1'b0;
        @(posedge clock) #1;
        check("reset", {7'h0, busy, aluRsp.flags}, 16'h0000);
        t_arith();
        t_logic();
        t_word();
        t_io();
        t_reset();
        wrap_up();
    end
endmodule : bal_byte_alu_test
